// *** verilog/dchp_pkg.sv ***
package dchp_pkg;
  localparam logic [15:0] ADDR_SERIAL_TIMER_CONTROL = 16'hFFC3;
  localparam logic [15:0] ADDR_SYSTEM_CONTROL       = 16'hFFC4;
  localparam logic [15:0] ADDR_HOST_PORT_CONTROL    = 16'hFFF0;
  localparam logic [15:0] ADDR_IN_CH1               = 16'hFFF4;
  localparam logic [15:0] ADDR_OUT_CH1              = 16'hFFF5;
  localparam logic [15:0] ADDR_STATUS_CH1           = 16'hFFF6;
  localparam logic [15:0] ADDR_IN_CH2               = 16'hFFFC;
  localparam logic [15:0] ADDR_OUT_CH2              = 16'hFFFD;
  localparam logic [15:0] ADDR_STATUS_CH2           = 16'hFFFE;
  localparam logic [7:0]  RST_SERIAL_TIMER_CONTROL  = 8'h00;
  localparam logic [7:0]  RST_SYSTEM_CONTROL        = 8'h09;
  localparam logic [7:0]  RST_HOST_PORT_CONTROL     = 8'hF8;
  localparam logic [7:0]  RST_STATUS                = 8'h00;
  localparam logic [7:0]  MASK_SYSTEM_CONTROL_WRITABLE       = 8'hF7;
  localparam logic [7:0]  MASK_HOST_PORT_CONTROL_WRITABLE        = 8'h07;
  localparam logic [7:0]  MASK_STATUS_USER          = 8'hF4;
  localparam int          POS_HOST_PORT_ENABLE      = 1;
  localparam int          POS_STROBE_PIN_SELECT     = 3;
  localparam int          POS_GATE_A20_EN           = 0;
  localparam int          POS_CMD_DATA              = 3;
  localparam int          POS_IBF                   = 1;
  localparam int          POS_OBF                   = 0;
  localparam int          FIFO_DEPTH                = 4;
  localparam int          FIFO_WIDTH                = 10;

  // one host write: channel, command flag, byte
  typedef struct packed {
    logic       chan;
    logic       cmd;
    logic [7:0] data;
  } dchp_hwr_s;
endpackage

// *** verilog/dchp_fifo.sv ***
`timescale 1ns/1ps
module dchp_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input  wire logic             clk_sys,
  input  wire logic             reset_n,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW-1:0]    wr_ptr_ff;
  logic [AW-1:0]    rd_ptr_ff;
  logic [AW:0]      count_ff;
  wire              push = in_valid && in_ready;
  wire              pop  = out_valid && out_ready;

  assign in_ready  = (count_ff != (AW+1)'(DEPTH));
  assign out_valid = (count_ff != '0);
  assign out_data  = mem_ff[rd_ptr_ff];

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      count_ff  <= '0;
    end else begin
      if (push) wr_ptr_ff <= (wr_ptr_ff == AW'(DEPTH-1)) ? '0 : wr_ptr_ff + 1'b1;
      if (pop)  rd_ptr_ff <= (rd_ptr_ff == AW'(DEPTH-1)) ? '0 : rd_ptr_ff + 1'b1;
      count_ff <= count_ff + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  // storage has no reset: contents are undefined until written
  always_ff @(posedge clk_sys) begin
    if (push) mem_ff[wr_ptr_ff] <= in_data;
  end
endmodule

// *** verilog/dchp_host_port.sv ***
`timescale 1ns/1ps
module dchp_host_port
  import dchp_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        reset_n,
  input  wire logic [15:0] cpu_addr,
  input  wire logic        cpu_rd,
  input  wire logic        cpu_wr,
  input  wire logic [7:0]  cpu_wdata,
  output logic [7:0]       cpu_rdata,
  input  wire logic        host_read_strobe_n,
  input  wire logic        host_write_strobe_n,
  input  wire logic        alt_host_write_strobe_n,
  input  wire logic        channel_one_select_n,
  input  wire logic        channel_two_select_n,
  input  wire logic        alt_channel_two_select_n,
  input  wire logic        command_data_select,
  input  wire logic [7:0]  host_data_bus_in,
  output logic [7:0]       host_data_bus_out,
  output logic             host_data_bus_oe,
  output logic             host_irq_one,
  input  wire logic        irq_one_set,
  output logic             host_irq_eleven,
  input  wire logic        irq_eleven_set,
  output logic             host_irq_twelve,
  input  wire logic        irq_twelve_set,
  output logic             gate_a20_out,
  input  wire logic        gate_a20_set
);
  logic [7:0] stc_ff, sys_ff, hpc_ff;
  logic [7:0] in1_ff, in2_ff, out1_ff, out2_ff, st1_ff, st2_ff;
  logic [7:0] cpu_rdata_ff;
  logic [7:0] hbus_out_ff;
  logic       hbus_oe_ff;
  logic       irq1_ff, irq11_ff, irq12_ff, a20_ff;
  // three-stage pin synchroniser: rd, wr, cs1, cs2, ha0
  logic [4:0] s1_ff, s2_ff, s3_ff, pin_ff;
  logic [7:0] d1_ff, d2_ff;
  logic       wr_q_ff, rd_q_ff;

  wire strobe_pin_select = stc_ff[POS_STROBE_PIN_SELECT];
  wire host_port_enable  = sys_ff[POS_HOST_PORT_ENABLE];
  wire wr_pin  = strobe_pin_select ? alt_host_write_strobe_n : host_write_strobe_n;
  wire cs2_pin = strobe_pin_select ? alt_channel_two_select_n : channel_two_select_n;
  wire [4:0] raw_pins = {command_data_select, cs2_pin, channel_one_select_n, wr_pin, host_read_strobe_n};

  // a change is accepted once stages two and three agree
  wire [4:0] nxt_pin = (s2_ff == s3_ff) ? s3_ff : pin_ff;

  wire rd_n  = pin_ff[0];
  wire wr_n  = pin_ff[1];
  wire cs1_n = pin_ff[2];
  wire cs2_n = pin_ff[3];
  wire ha0   = pin_ff[4];
  // exactly one select low addresses a channel
  wire sel_one = !cs1_n && cs2_n;
  wire sel_two = cs1_n && !cs2_n;
  wire sel_any = (sel_one || sel_two) && host_port_enable;

  wire host_wr_act = !wr_n;
  wire host_rd_act = !rd_n && sel_any;
  wire wr_rise     = wr_q_ff && !host_wr_act;
  wire rd_fall     = host_rd_act && !rd_q_ff;
  wire host_rd_out1 = rd_fall && sel_one && !ha0;
  wire host_rd_out2 = rd_fall && sel_two && !ha0;

  // host write goes through the fifo so cpu side logic stays simple
  logic      wr_sel_one_ff, wr_sel_two_ff, wr_ha0_ff;
  dchp_hwr_s hwr_in, hwr_out;
  logic      fifo_out_valid;
  wire       fifo_push = wr_rise && (wr_sel_one_ff || wr_sel_two_ff) && host_port_enable;
  assign hwr_in = '{chan: wr_sel_two_ff, cmd: wr_ha0_ff, data: d2_ff};

  dchp_fifo #(.WIDTH(FIFO_WIDTH), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk_sys   (clk_sys),
    .reset_n   (reset_n),
    .in_valid  (fifo_push),
    .in_ready  (),
    .in_data   (hwr_in),
    .out_valid (fifo_out_valid),
    .out_ready (1'b1),
    .out_data  (hwr_out)
  );
  // fifo drains every cycle; in_ready only falls if writes outpace the clock
  wire apply_one = fifo_out_valid && !hwr_out.chan;
  wire apply_two = fifo_out_valid && hwr_out.chan;

  wire cpu_wr_sys  = cpu_wr && (cpu_addr == ADDR_SYSTEM_CONTROL);
  wire cpu_wr_stc  = cpu_wr && (cpu_addr == ADDR_SERIAL_TIMER_CONTROL);
  wire cpu_wr_hpc  = cpu_wr && (cpu_addr == ADDR_HOST_PORT_CONTROL);
  wire cpu_wr_out1 = cpu_wr && (cpu_addr == ADDR_OUT_CH1);
  wire cpu_wr_out2 = cpu_wr && (cpu_addr == ADDR_OUT_CH2);
  wire cpu_wr_st1  = cpu_wr && (cpu_addr == ADDR_STATUS_CH1);
  wire cpu_wr_st2  = cpu_wr && (cpu_addr == ADDR_STATUS_CH2);
  wire cpu_rd_in1  = cpu_rd && (cpu_addr == ADDR_IN_CH1);
  wire cpu_rd_in2  = cpu_rd && (cpu_addr == ADDR_IN_CH2);

  // status next values: set beats clear for both flags
  function automatic logic [7:0] nxt_status(
    input logic [7:0] cur, input logic cwr, input logic [7:0] wd,
    input logic hset, input logic hcmd, input logic rdin,
    input logic owr, input logic ordh);
    logic [7:0] v;
    v = cwr ? ((cur & ~MASK_STATUS_USER) | (wd & MASK_STATUS_USER)) : cur;
    if (hset) v[POS_CMD_DATA] = hcmd;
    if (hset) v[POS_IBF] = 1'b1;
    else if (rdin) v[POS_IBF] = 1'b0;
    if (owr) v[POS_OBF] = 1'b1;
    else if (ordh) v[POS_OBF] = 1'b0;
    return v;
  endfunction
  wire [7:0] nxt_st1 = nxt_status(st1_ff, cpu_wr_st1, cpu_wdata, apply_one, hwr_out.cmd,
                                  cpu_rd_in1, cpu_wr_out1, host_rd_out1);
  wire [7:0] nxt_st2 = nxt_status(st2_ff, cpu_wr_st2, cpu_wdata, apply_two, hwr_out.cmd,
                                  cpu_rd_in2, cpu_wr_out2, host_rd_out2);

  wire [7:0] nxt_sys = (sys_ff & ~MASK_SYSTEM_CONTROL_WRITABLE) | (cpu_wdata & MASK_SYSTEM_CONTROL_WRITABLE);
  wire [7:0] nxt_hpc = RST_HOST_PORT_CONTROL | (cpu_wdata & MASK_HOST_PORT_CONTROL_WRITABLE);

  // unmapped cpu addresses and the absent host path read as zero
  wire [7:0] nxt_cpu_rdata =
    (cpu_addr == ADDR_SERIAL_TIMER_CONTROL) ? stc_ff :
    (cpu_addr == ADDR_SYSTEM_CONTROL)       ? sys_ff :
    (cpu_addr == ADDR_HOST_PORT_CONTROL)    ? hpc_ff :
    (cpu_addr == ADDR_IN_CH1)               ? in1_ff :
    (cpu_addr == ADDR_OUT_CH1)              ? out1_ff :
    (cpu_addr == ADDR_STATUS_CH1)           ? st1_ff :
    (cpu_addr == ADDR_IN_CH2)               ? in2_ff :
    (cpu_addr == ADDR_OUT_CH2)              ? out2_ff :
    (cpu_addr == ADDR_STATUS_CH2)           ? st2_ff : 8'h00;

  wire [7:0] nxt_hbus = sel_two ? (ha0 ? st2_ff : out2_ff)
                                : (ha0 ? st1_ff : out1_ff);

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      s1_ff  <= 5'h1F;
      s2_ff  <= 5'h1F;
      s3_ff  <= 5'h1F;
      pin_ff <= 5'h1F;
      d1_ff  <= 8'h00;
      d2_ff  <= 8'h00;
    end else begin
      s1_ff  <= raw_pins;
      s2_ff  <= s1_ff;
      s3_ff  <= s2_ff;
      pin_ff <= nxt_pin;
      d1_ff  <= host_data_bus_in;
      d2_ff  <= d1_ff;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      wr_q_ff       <= 1'b0;
      rd_q_ff       <= 1'b0;
      wr_sel_one_ff <= 1'b0;
      wr_sel_two_ff <= 1'b0;
      wr_ha0_ff     <= 1'b0;
    end else begin
      wr_q_ff <= host_wr_act;
      rd_q_ff <= host_rd_act;
      // selects and address captured while the strobe is low, held and used at its rise
      if (host_wr_act) begin
        wr_sel_one_ff <= sel_one;
        wr_sel_two_ff <= sel_two;
        wr_ha0_ff     <= ha0;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      stc_ff <= RST_SERIAL_TIMER_CONTROL;
      sys_ff <= RST_SYSTEM_CONTROL;
      hpc_ff <= RST_HOST_PORT_CONTROL;
      st1_ff <= RST_STATUS;
      st2_ff <= RST_STATUS;
    end else begin
      if (cpu_wr_stc) stc_ff <= cpu_wdata;
      if (cpu_wr_sys) sys_ff <= nxt_sys;
      if (cpu_wr_hpc) hpc_ff <= nxt_hpc;
      st1_ff <= nxt_st1;
      st2_ff <= nxt_st2;
    end
  end

  // data registers reset to zero for determinism
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      in1_ff  <= 8'h00;
      in2_ff  <= 8'h00;
      out1_ff <= 8'h00;
      out2_ff <= 8'h00;
    end else begin
      if (apply_one)   in1_ff  <= hwr_out.data;
      if (apply_two)   in2_ff  <= hwr_out.data;
      if (cpu_wr_out1) out1_ff <= cpu_wdata;
      if (cpu_wr_out2) out2_ff <= cpu_wdata;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      cpu_rdata_ff <= 8'h00;
      hbus_out_ff  <= 8'h00;
      hbus_oe_ff   <= 1'b0;
      irq1_ff      <= 1'b0;
      irq11_ff     <= 1'b0;
      irq12_ff     <= 1'b0;
      a20_ff       <= 1'b0;
    end else begin
      cpu_rdata_ff <= nxt_cpu_rdata;
      hbus_out_ff  <= nxt_hbus;
      hbus_oe_ff   <= host_rd_act;
      irq1_ff      <= irq_one_set;
      irq11_ff     <= irq_eleven_set;
      irq12_ff     <= irq_twelve_set;
      a20_ff       <= hpc_ff[POS_GATE_A20_EN] ? gate_a20_set : a20_ff;
    end
  end

  assign cpu_rdata         = cpu_rdata_ff;
  assign host_data_bus_out = hbus_out_ff;
  assign host_data_bus_oe  = hbus_oe_ff;
  assign host_irq_one      = irq1_ff;
  assign host_irq_eleven   = irq11_ff;
  assign host_irq_twelve   = irq12_ff;
  assign gate_a20_out      = a20_ff;
endmodule

// *** bench/dchp_host_port_monitor.sv ***
`timescale 1ns/1ps
module dchp_host_port_monitor
  import dchp_pkg::*;
(
  input wire logic        clk_sys,
  input wire logic        reset_n,
  input wire logic [15:0] cpu_addr,
  input wire logic        cpu_wr,
  input wire logic [7:0]  cpu_rdata,
  input wire logic        host_read_strobe_n,
  input wire logic        channel_one_select_n,
  input wire logic        channel_two_select_n,
  input wire logic        alt_channel_two_select_n,
  input wire logic        host_data_bus_oe,
  input wire logic        host_irq_one,
  input wire logic        host_irq_eleven,
  input wire logic        host_irq_twelve,
  input wire logic        irq_one_set,
  input wire logic        irq_eleven_set,
  input wire logic        irq_twelve_set,
  input wire logic        gate_a20_out,
  input wire logic        gate_a20_set
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!reset_n);

  sequence s_obf_write;
    (cpu_wr && cpu_addr == ADDR_OUT_CH1) ##1 !cpu_wr ##1 (cpu_addr == ADDR_STATUS_CH1);
  endsequence

  a_drive_needs_read: assert property ($rose(host_data_bus_oe) |-> !host_read_strobe_n)
    else $error("bus driven without read strobe");
  a_drive_released: assert property ($rose(host_read_strobe_n) |-> ##[1:10] !host_data_bus_oe)
    else $error("bus still driven after read ended");
  a_idle_no_drive: assert property ((channel_one_select_n && channel_two_select_n && alt_channel_two_select_n)[*8]
    |=> !host_data_bus_oe)
    else $error("bus driven with no channel selected");
  a_irq_pins_follow: assert property ({host_irq_one, host_irq_eleven, host_irq_twelve}
    == $past({irq_one_set, irq_eleven_set, irq_twelve_set}))
    else $error("host interrupt outputs wrong");
  a_gate_follows: assert property ($changed(gate_a20_out) |-> gate_a20_out == $past(gate_a20_set))
    else $error("gate output changed without cause");
  a_sysctl_bit_fixed: assert property (cpu_addr == ADDR_SYSTEM_CONTROL |=> cpu_rdata[3])
    else $error("system control bit 3 not one");
  a_portctl_high_bits: assert property (cpu_addr == ADDR_HOST_PORT_CONTROL |=> cpu_rdata[7:3] == 5'h1F)
    else $error("port control reserved bits not one");
  a_obf_set_write: assert property (s_obf_write |=> cpu_rdata[POS_OBF])
    else $error("output full flag not set by cpu write");
endmodule

bind dchp_host_port dchp_host_port_monitor mon (.clk_sys, .reset_n, .cpu_addr, .cpu_wr, .cpu_rdata,
  .host_read_strobe_n, .channel_one_select_n, .channel_two_select_n, .alt_channel_two_select_n,
  .host_data_bus_oe, .host_irq_one, .host_irq_eleven, .host_irq_twelve, .irq_one_set, .irq_eleven_set,
  .irq_twelve_set, .gate_a20_out, .gate_a20_set);

// *** bench/dchp_host_model.sv ***
`timescale 1ns/1ps
module dchp_host_model (
  input  wire logic       clk_sys,
  output logic            host_read_strobe_n,
  output logic            host_write_strobe_n,
  output logic            alt_host_write_strobe_n,
  output logic            channel_one_select_n,
  output logic            channel_two_select_n,
  output logic            alt_channel_two_select_n,
  output logic            command_data_select,
  output logic [7:0]      host_data_bus_in,
  input  wire logic [7:0] host_data_bus_out,
  input  wire logic       host_data_bus_oe
);
  logic       drv_en = 1'b0;
  logic [7:0] drv_data = 8'h00;
  logic [7:0] last_ff = 8'h00;
  // a floating bus wanders so a stale byte never passes as read data
  assign host_data_bus_in = host_data_bus_oe ? host_data_bus_out : drv_en ? drv_data : ~last_ff;
  always @(posedge clk_sys) last_ff <= host_data_bus_in;
  initial begin
    {host_read_strobe_n, host_write_strobe_n, alt_host_write_strobe_n} = 3'h7;
    {channel_one_select_n, channel_two_select_n, alt_channel_two_select_n} = 3'h7;
    command_data_select = 1'b0;
  end
  // exactly one select, nothing but that one select pin set to lvl
  task automatic sel(input logic ch2, input logic alt, input logic lvl);
    if (!ch2) channel_one_select_n <= lvl;
    else if (alt) alt_channel_two_select_n <= lvl;
    else channel_two_select_n <= lvl;
  endtask
  task automatic host_write(input logic ch2, input logic alt, input logic ha0, input logic [7:0] d);
    @(posedge clk_sys);
    sel(ch2, alt, 1'b0);
    command_data_select <= ha0;
    drv_en <= 1'b1;
    drv_data <= d;
    {alt_host_write_strobe_n, host_write_strobe_n} <= alt ? 2'b01 : 2'b10;
    repeat (8) @(posedge clk_sys);
    {alt_host_write_strobe_n, host_write_strobe_n} <= 2'b11;
    // data held well past the filtered rise, where the port samples it
    repeat (10) @(posedge clk_sys);
    sel(ch2, alt, 1'b1);
    drv_en <= 1'b0;
    repeat (6) @(posedge clk_sys);
  endtask
  task automatic host_read(input logic ch2, input logic ha0, output logic [7:0] d, output logic ok);
    int n;
    @(posedge clk_sys);
    sel(ch2, 1'b0, 1'b0);
    command_data_select <= ha0;
    host_read_strobe_n <= 1'b0;
    ok = 1'b0;
    for (n = 0; n < 16 && !ok; n++) begin
      @(posedge clk_sys);
      ok = host_data_bus_oe;
      d = host_data_bus_in;
    end
    host_read_strobe_n <= 1'b1;
    sel(ch2, 1'b0, 1'b1);
    repeat (10) @(posedge clk_sys);
  endtask
endmodule

// *** bench/dchp_host_port_bench.sv ***
`timescale 1ns/1ps
module dchp_host_port_bench
  import dchp_pkg::*;
;
  logic        clk_sys = 1'b0;
  logic        reset_n = 1'b0;
  logic [15:0] cpu_addr = 16'h0000;
  logic        cpu_rd = 1'b0;
  logic        cpu_wr = 1'b0;
  logic [7:0]  cpu_wdata = 8'h00;
  logic        irq_one_set = 1'b0, irq_eleven_set = 1'b0, irq_twelve_set = 1'b0, gate_a20_set = 1'b0;
  logic [7:0]  cpu_rdata, host_data_bus_in, host_data_bus_out;
  logic        host_read_strobe_n, host_write_strobe_n, alt_host_write_strobe_n, command_data_select;
  logic        channel_one_select_n, channel_two_select_n, alt_channel_two_select_n, host_data_bus_oe;
  logic        host_irq_one, host_irq_eleven, host_irq_twelve, gate_a20_out;
  int          n_fail = 0;
  int          checked = 0;

  dchp_host_port uut (.clk_sys, .reset_n, .cpu_addr, .cpu_rd, .cpu_wr, .cpu_wdata, .cpu_rdata,
    .host_read_strobe_n, .host_write_strobe_n, .alt_host_write_strobe_n, .channel_one_select_n,
    .channel_two_select_n, .alt_channel_two_select_n, .command_data_select, .host_data_bus_in,
    .host_data_bus_out, .host_data_bus_oe, .host_irq_one, .irq_one_set, .host_irq_eleven, .irq_eleven_set,
    .host_irq_twelve, .irq_twelve_set, .gate_a20_out, .gate_a20_set);
  dchp_host_model host (.clk_sys, .host_read_strobe_n, .host_write_strobe_n, .alt_host_write_strobe_n,
    .channel_one_select_n, .channel_two_select_n, .alt_channel_two_select_n, .command_data_select,
    .host_data_bus_in, .host_data_bus_out, .host_data_bus_oe);

  always #4 clk_sys = ~clk_sys;

  task automatic results;
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cpu_write(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    cpu_addr <= a;
    cpu_wdata <= d;
    cpu_wr <= 1'b1;
    @(posedge clk_sys);
    cpu_wr <= 1'b0;
  endtask
  task automatic rchk(input logic [15:0] a, input logic [7:0] exp);
    @(posedge clk_sys);
    cpu_addr <= a;
    cpu_rd <= 1'b1;
    @(posedge clk_sys);
    cpu_rd <= 1'b0;
    #1 chk(cpu_rdata, exp);
  endtask
  task automatic hread(input logic ch2, input logic ha0, input logic [7:0] exp);
    logic [7:0] d;
    logic       ok;
    host.host_read(ch2, ha0, d, ok);
    if (!ok) begin
      n_fail++;
      results();
    end else begin
      chk(d, exp);
    end
  endtask

  logic [15:0] raddr [5] = '{16'hFFC3, 16'hFFC4, 16'hFFF0, 16'hFFF6, 16'hFFFE};
  logic [7:0]  rrst [5] = '{8'h00, 8'h09, 8'hF8, 8'h00, 8'h00};
  initial begin
    repeat (8) @(posedge clk_sys);
    reset_n <= 1'b1;
    foreach (raddr[i]) rchk(raddr[i], rrst[i]);
    host.host_write(1'b0, 1'b0, 1'b1, 8'h11);
    rchk(ADDR_STATUS_CH1, 8'h00);
    cpu_write(ADDR_SYSTEM_CONTROL, 8'hF0);
    rchk(ADDR_SYSTEM_CONTROL, 8'hF8);
    cpu_write(ADDR_SYSTEM_CONTROL, 8'h02);
    rchk(ADDR_SYSTEM_CONTROL, 8'h0A);
    cpu_write(ADDR_HOST_PORT_CONTROL, 8'hFF);
    rchk(ADDR_HOST_PORT_CONTROL, 8'hFF);
    cpu_write(ADDR_HOST_PORT_CONTROL, 8'h00);
    rchk(ADDR_HOST_PORT_CONTROL, 8'hF8);
    cpu_write(ADDR_STATUS_CH1, 8'hFF);
    rchk(ADDR_STATUS_CH1, 8'hF4);
    cpu_write(ADDR_STATUS_CH2, 8'h0B);
    rchk(ADDR_STATUS_CH2, 8'h00);
    cpu_write(ADDR_STATUS_CH1, 8'h00);
    host.host_write(1'b0, 1'b0, 1'b1, 8'hA5);
    rchk(ADDR_STATUS_CH1, 8'h0A);
    rchk(ADDR_IN_CH1, 8'hA5);
    rchk(ADDR_STATUS_CH1, 8'h08);
    host.host_write(1'b1, 1'b0, 1'b0, 8'h3C);
    rchk(ADDR_STATUS_CH2, 8'h02);
    rchk(ADDR_IN_CH2, 8'h3C);
    cpu_write(ADDR_IN_CH1, 8'hFF);
    rchk(ADDR_IN_CH1, 8'hA5);
    cpu_write(ADDR_OUT_CH1, 8'h5A);
    rchk(ADDR_STATUS_CH1, 8'h09);
    rchk(ADDR_OUT_CH1, 8'h5A);
    hread(1'b0, 1'b0, 8'h5A);
    rchk(ADDR_STATUS_CH1, 8'h08);
    hread(1'b0, 1'b1, 8'h08);
    cpu_write(ADDR_OUT_CH2, 8'hC3);
    hread(1'b1, 1'b0, 8'hC3);
    // alternate pins must be ignored until strobe select is set
    host.host_write(1'b1, 1'b1, 1'b0, 8'h77);
    rchk(ADDR_STATUS_CH2, 8'h00);
    cpu_write(ADDR_SERIAL_TIMER_CONTROL, 8'h08);
    host.host_write(1'b1, 1'b1, 1'b1, 8'h66);
    rchk(ADDR_STATUS_CH2, 8'h0A);
    rchk(ADDR_IN_CH2, 8'h66);
    cpu_write(ADDR_HOST_PORT_CONTROL, 8'h01);
    {irq_one_set, irq_eleven_set, irq_twelve_set, gate_a20_set} <= 4'hB;
    repeat (3) @(posedge clk_sys);
    #1 chk({4'h0, host_irq_one, host_irq_eleven, host_irq_twelve, gate_a20_out}, 8'h0B);
    results();
  end
endmodule
